// ==== logic/srcr_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the
// switch / reset-pin configuration slice.
// Assumes a 20 MHz system clock and an 8-bit internal register port.
`ifndef SRCR_CFG_SVH
`define SRCR_CFG_SVH

// ==========================================================
// Register offsets
`define SRCR_ADDR_W 8
`define SRCR_OFS_PIN_LIMIT 8'h14
`define SRCR_OFS_FAIL_DISCH 8'h15
`define SRCR_OFS_BUCK_ONE 8'h16

// ==========================================================
// Reset values and writable masks
`define SRCR_RST_PIN_LIMIT 8'h40
`define SRCR_RST_FAIL_DISCH 8'h00
`define SRCR_RST_BUCK_ONE 8'h80
`define SRCR_MASK_PIN_LIMIT 8'hcf
`define SRCR_MASK_FAIL_DISCH 8'h3f
`define SRCR_MASK_BUCK_ONE 8'hbf

// ==========================================================
// Field positions
`define SRCR_BIT_WARM_SEL 7
`define SRCR_BIT_HYST_SEL 6
`define SRCR_LSB_SW3_LIMIT 2
`define SRCR_LSB_SW2_LIMIT 0
`define SRCR_LSB_FAIL_DIS 3
`define SRCR_LSB_DISCH_EN 0
`define SRCR_BIT_LIGHT_LOAD 7
`define SRCR_LSB_VOLTAGE 0
`define SRCR_VOLTAGE_W 6

// ==========================================================
// Timing
`define SRCR_CLK_KHZ 20000
`define SRCR_BLANK_TIME_MS 5
`define SRCR_BLANK_CYCLES (`SRCR_BLANK_TIME_MS * `SRCR_CLK_KHZ)

`endif

// ==== logic/srcr_pkg.sv ====
// Types shared by the switch / reset-pin configuration slice.
// Assumes the constants of srcr_cfg.svh; holds no numbers of its own.
package srcr_pkg;

    // Registered state of the register slice
    typedef struct packed {
        logic [7:0] pin_limit;
        logic [7:0] fail_disch;
        logic [7:0] buck_one;
        logic [7:0] rd_data;
        logic [2:0] switch_on;
        logic [2:0] discharge_on;
        logic pin_out;
        logic pin_oe;
        logic buck_warm_reset;
        logic monitor_blank;
    } srcr_state_t;

endpackage

// ==== logic/srcr_pin_sync.sv ====
// Two-flop synchroniser for pins that arrive from outside sys_clk.
// Assumes the inputs are plain levels; the first stage is read only by the second.
`timescale 1ns/10ps
`default_nettype none

module srcr_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] stage_one;
        logic [WIDTH-1:0] stage_two;
    } srcr_sync_t;

    srcr_sync_t q;
    srcr_sync_t next_q;

    // ==========================================================
    // Shift chain, one lane per pin
    always_comb
    begin
        next_q = q;
        for (int i = 0; i < WIDTH; i++)
        begin
            next_q.stage_one[i] = pin_async[i];
            next_q.stage_two[i] = q.stage_one[i];
        end
    end

    // Idle-high reset, pins are pulled up when unused
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            q <= '1;
        else
            q <= next_q;
    end

    assign pin_sync = q.stage_two;

endmodule
`default_nettype wire

// ==== logic/srcr_blank_timer.sv ====
// Retriggerable blanking window for the buck monitor.
// Assumes a one-cycle start pulse on sys_clk; busy stays high CYCLES cycles.
`timescale 1ns/10ps
`default_nettype none

module srcr_blank_timer #(
    parameter int CYCLES = 100000,
    parameter int CNT_W = 17
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    output logic busy
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic busy;
    } srcr_timer_t;

    srcr_timer_t q;
    srcr_timer_t next_q;

    // ==========================================================
    // Reload on every start, else count down to zero
    always_comb
    begin
        next_q = q;
        if (start)
            next_q.count = CNT_W'(CYCLES);
        else if (q.count != '0)
            next_q.count = q.count - CNT_W'(1);
        next_q.busy = (next_q.count != '0);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            q <= '0;
        else
            q <= next_q;
    end

    assign busy = q.busy;

endmodule
`default_nettype wire

// ==== logic/srcr_regs.sv ====
// Reset-pin, load-switch and first buck control registers.
// Assumes a same-clock register port behind the serial interface, an unlock
// level from the password logic, and raw pins for the third general pin and
// the power-fail comparator.
//
// Overview of operation
// [R01] Pin/limit register at 0x14, resets 0x40
// [R02] Bit 7 selects warm-reset input or output
// [R03] Warm-reset mode ignores output level bit
// [R04] Bit 6 hysteresis select, resets high
// [R05] Bits 3-2 switch three limit
// [R06] Bits 1-0 switch two limit
// [R07] Fail/discharge register 0x15, resets zero
// [R08] Fail bits force switch off on low comparator
// [R09] Discharge bits discharge switch when off
// [R10] Buck one register 0x16, resets 0x80
// [R11] Bit 7 selects light-load pulse skipping
// [R12] Buck one writes need completed password
// [R13] Buck one write starts 5 ms blanking
// [R14] Host sets go bit for new voltage
// [R15] Reserved bits read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
`include "srcr_cfg.svh"

module srcr_regs #(
    parameter int BLANK_CYCLES = `SRCR_BLANK_CYCLES,
    parameter int BLANK_CNT_W = 17
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic unlocked,
    input wire logic third_pin_level,
    input wire logic [2:0] switch_enable,
    input wire logic third_general_pin_in,
    input wire logic power_fail_comparator_out,
    output logic third_general_pin_out,
    output logic third_general_pin_oe,
    output logic buck_warm_reset,
    output logic warm_reset_pin_select,
    output logic lockout_hysteresis_select,
    output logic [1:0] switch_three_limit_select,
    output logic [1:0] switch_two_limit_select,
    output logic [2:0] switch_on,
    output logic [2:0] discharge_on,
    output logic light_load_pulse_skip,
    output logic [5:0] buck_one_voltage,
    output logic monitor_blank
);

    srcr_pkg::srcr_state_t q;
    srcr_pkg::srcr_state_t next_q;

    logic [1:0] pins_sync;
    logic pin_sync;
    logic pfo_sync;
    logic wr_ok;
    logic wr_buck;
    logic blank_busy;

    // ==========================================================
    // Pin synchronisers
    srcr_pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_async({power_fail_comparator_out, third_general_pin_in}),
        .pin_sync(pins_sync)
    );

    assign pin_sync = pins_sync[0];
    assign pfo_sync = pins_sync[1];

    // Write qualification
    assign wr_ok = wr_en & unlocked; // [R12]
    assign wr_buck = wr_ok & (wr_addr == `SRCR_OFS_BUCK_ONE);

    // ==========================================================
    // Monitor blanking window
    srcr_blank_timer #(
        .CYCLES(BLANK_CYCLES),
        .CNT_W(BLANK_CNT_W)
    ) u_blank (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(wr_buck), // [R13]
        .busy(blank_busy)
    );

    // ==========================================================
    // Register writes, readback and derived controls
    always_comb
    begin
        next_q = q;
        // Writable bits only; reserved bits keep zero
        if (wr_ok && wr_addr == `SRCR_OFS_PIN_LIMIT)
            next_q.pin_limit = wr_data & `SRCR_MASK_PIN_LIMIT; // [R01] [R15]
        if (wr_ok && wr_addr == `SRCR_OFS_FAIL_DISCH)
            next_q.fail_disch = wr_data & `SRCR_MASK_FAIL_DISCH; // [R07] [R15]
        if (wr_buck)
            next_q.buck_one = wr_data & `SRCR_MASK_BUCK_ONE; // [R10] [R15]
        // Registered readback, unmapped offsets read zero
        if (rd_en)
        begin
            case (rd_addr)
                `SRCR_OFS_PIN_LIMIT: next_q.rd_data = q.pin_limit;
                `SRCR_OFS_FAIL_DISCH: next_q.rd_data = q.fail_disch;
                `SRCR_OFS_BUCK_ONE: next_q.rd_data = q.buck_one;
                default: next_q.rd_data = 8'h00;
            endcase
        end
        // Power-fail gating and discharge per switch
        for (int i = 0; i < 3; i++)
        begin
            next_q.switch_on[i] = switch_enable[i]
                & ~(q.fail_disch[`SRCR_LSB_FAIL_DIS + i] & ~pfo_sync); // [R08]
            next_q.discharge_on[i] = q.fail_disch[`SRCR_LSB_DISCH_EN + i]
                & ~next_q.switch_on[i]; // [R09]
        end
        // Third pin: open-drain output or warm-reset input
        next_q.pin_out = 1'b0;
        if (q.pin_limit[`SRCR_BIT_WARM_SEL])
        begin
            next_q.pin_oe = 1'b0; // [R03]
            next_q.buck_warm_reset = ~pin_sync; // [R02]
        end
        else
        begin
            next_q.pin_oe = ~third_pin_level; // [R02]
            next_q.buck_warm_reset = 1'b0;
        end
        next_q.monitor_blank = blank_busy; // [R13]
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.pin_limit <= `SRCR_RST_PIN_LIMIT; // [R01] [R04]
            q.fail_disch <= `SRCR_RST_FAIL_DISCH; // [R07]
            q.buck_one <= `SRCR_RST_BUCK_ONE; // [R10]
        end
        else
            q <= next_q;
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign rd_data = q.rd_data;
    assign third_general_pin_out = q.pin_out;
    assign third_general_pin_oe = q.pin_oe;
    assign buck_warm_reset = q.buck_warm_reset;
    assign warm_reset_pin_select = q.pin_limit[`SRCR_BIT_WARM_SEL]; // [R02]
    assign lockout_hysteresis_select = q.pin_limit[`SRCR_BIT_HYST_SEL]; // [R04]
    assign switch_three_limit_select = q.pin_limit[`SRCR_LSB_SW3_LIMIT +: 2]; // [R05]
    assign switch_two_limit_select = q.pin_limit[`SRCR_LSB_SW2_LIMIT +: 2]; // [R06]
    assign switch_on = q.switch_on;
    assign discharge_on = q.discharge_on;
    assign light_load_pulse_skip = q.buck_one[`SRCR_BIT_LIGHT_LOAD]; // [R11]
    assign buck_one_voltage = q.buck_one[`SRCR_LSB_VOLTAGE +: `SRCR_VOLTAGE_W]; // [R10]
    assign monitor_blank = q.monitor_blank;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_buck_write;
        wr_en && unlocked && wr_addr == `SRCR_OFS_BUCK_ONE;
    endsequence

    sequence s_locked_write;
        wr_en && !unlocked;
    endsequence

    sequence s_limit_write;
        wr_en && unlocked && wr_addr == `SRCR_OFS_PIN_LIMIT;
    endsequence

    sequence s_fail_write;
        wr_en && unlocked && wr_addr == `SRCR_OFS_FAIL_DISCH;
    endsequence

    sequence s_unmapped_read;
        rd_en && rd_addr != `SRCR_OFS_PIN_LIMIT && rd_addr != `SRCR_OFS_FAIL_DISCH
            && rd_addr != `SRCR_OFS_BUCK_ONE;
    endsequence

    AST_RESET_VALUES: assert property ( // [R01]
        @(posedge sys_clk) disable iff (1'b0)
        $past(reset) |-> q.pin_limit == 8'h40 && q.fail_disch == 8'h00
            && q.buck_one == 8'h80)
        else $error("register reset values wrong");

    AST_LOCKED_IGNORED: assert property ( // [R12]
        s_locked_write |=> $stable(q.buck_one) && $stable(q.pin_limit)
            && $stable(q.fail_disch))
        else $error("write taken while locked");

    AST_BLANK_START: assert property ( // [R13]
        s_buck_write |=> ##1 monitor_blank [*8])
        else $error("blanking did not follow buck write");

    AST_PIN_IGNORED: assert property ( // [R03]
        warm_reset_pin_select |=> !third_general_pin_oe)
        else $error("pin driven in warm-reset mode");

    AST_FAIL_OFF: assert property ( // [R08]
        q.fail_disch[5] && !pfo_sync |=> !switch_on[2])
        else $error("switch three not forced off");

    AST_DISCHARGE: assert property ( // [R09]
        discharge_on[0] |-> !switch_on[0] && $past(q.fail_disch[0]) == 1'b1)
        else $error("discharge while switch on");

    AST_RESERVED_ZERO: assert property ( // [R15]
        q.pin_limit[5:4] == 2'b00 && q.fail_disch[7:6] == 2'b00
            && q.buck_one[6] == 1'b0)
        else $error("reserved bit set");

    AST_LIMIT_WRITE: assert property ( // [R05]
        s_limit_write |=> switch_three_limit_select == $past(wr_data[3:2])
            && switch_two_limit_select == $past(wr_data[1:0])
            && lockout_hysteresis_select == $past(wr_data[6]))
        else $error("limit fields not written");

    AST_LIGHT_LOAD: assert property ( // [R11]
        s_buck_write |=> light_load_pulse_skip == $past(wr_data[7]))
        else $error("light-load bit not written");

    AST_READBACK: assert property ( // [R07]
        rd_en && rd_addr == `SRCR_OFS_FAIL_DISCH && !wr_en |=>
            rd_data == q.fail_disch)
        else $error("readback mismatch");

    AST_WARM_SEL_WRITE: assert property ( // [R02]
        s_limit_write |=> warm_reset_pin_select == $past(wr_data[7]))
        else $error("warm-reset select not written");

    AST_WARM_FOLLOWS_PIN: assert property ( // [R02]
        warm_reset_pin_select |=> buck_warm_reset == !$past(pin_sync))
        else $error("warm reset does not follow the pin");

    AST_OUTPUT_MODE: assert property ( // [R02]
        !warm_reset_pin_select |=> !buck_warm_reset
            && third_general_pin_oe == !$past(third_pin_level))
        else $error("output mode pin level wrong");

    AST_FAIL_WRITE: assert property ( // [R07]
        s_fail_write |=> q.fail_disch == ($past(wr_data) & `SRCR_MASK_FAIL_DISCH))
        else $error("fail/discharge register not written");

    AST_VOLTAGE_WRITE: assert property ( // [R10]
        s_buck_write |=> buck_one_voltage == $past(wr_data[5:0]))
        else $error("voltage field not written");

    AST_BLANK_CAUSE: assert property ( // [R13]
        $rose(monitor_blank) |-> $past(wr_buck, 2))
        else $error("blanking without buck write");

    AST_UNMAPPED_READ: assert property ( // [R15]
        s_unmapped_read |=> rd_data == 8'h00)
        else $error("unmapped offset read nonzero");

    AST_READ_HOLD: assert property ( // [R01]
        !rd_en |=> $stable(rd_data))
        else $error("read data changed without a read");

    // ==========================================================
    // Per-switch gating and discharge checks
    for (genvar i = 0; i < 3; i++)
    begin : g_switch_checks
        AST_SWITCH_PASS: assert property ( // [R08]
            @(posedge sys_clk) disable iff (reset)
            !(q.fail_disch[`SRCR_LSB_FAIL_DIS + i] && !pfo_sync)
                |=> switch_on[i] == $past(switch_enable[i]))
            else $error("switch not following its enable");

        AST_SWITCH_FORCED_OFF: assert property ( // [R08]
            @(posedge sys_clk) disable iff (reset)
            q.fail_disch[`SRCR_LSB_FAIL_DIS + i] && !pfo_sync |=> !switch_on[i])
            else $error("switch not forced off on power fail");

        AST_DISCHARGE_WHEN_OFF: assert property ( // [R09]
            @(posedge sys_clk) disable iff (reset)
            $past(q.fail_disch[`SRCR_LSB_DISCH_EN + i]) && !switch_on[i]
                |-> discharge_on[i])
            else $error("no discharge while switch off");
    end

endmodule
`default_nettype wire

// ==== bench/srcr_host.sv ====
// Host model: drives the register port the way the serial host would.
// Assumes calls start 5 ns after a rising sys_clk edge.
`timescale 1ns/10ps
`default_nettype none

module srcr_host (
    input wire logic sys_clk,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [7:0] rd_addr,
    output logic unlocked
);
    // ==========================================
    // Idle port, password not yet given
    initial
    begin
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_en = 1'b0;
        rd_addr = 8'h00;
        unlocked = 1'b0;
    end

    // ==========================================
    // One-byte write; voltage goes before any go command
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge sys_clk);
        #5;
        wr_en = 1'b0;
        wr_addr = ~a; // Released lines show no stale value
        wr_data = ~d;
        @(posedge sys_clk); // Idle cycle keeps strobes apart
        #5;
    end
    endtask

    // One-byte read, data taken just after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
    begin
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge sys_clk);
        #5;
        d = rd_data;
        rd_en = 1'b0;
        rd_addr = ~a;
        @(posedge sys_clk); // Idle cycle keeps strobes apart
        #5;
    end
    endtask

    // Outcome of the password sequence
    task automatic set_unlock(input logic v);
    begin
        unlocked = v;
    end
    endtask
endmodule

`default_nettype wire

// ==== bench/srcr_regs_tb.sv ====
// Testbench of the register slice, driven through the host model.
// Assumes a short blanking count of 20 cycles.
`timescale 1ns/10ps
`default_nettype none

module srcr_regs_tb;
    logic sys_clk, reset, wr_en, rd_en, unlocked, tpl, pin_in, pfo;
    logic pin_out, pin_oe, warm_rst, warm_sel, hyst, llp, blank;
    logic [7:0] rd_data, wr_addr, wr_data, rd_addr;
    logic [2:0] sw_en, sw_on, dis_on;
    logic [1:0] lim3, lim2;
    logic [5:0] volt;
    int bad_count, check_count, n;

    srcr_host srcr_host_inst (.sys_clk(sys_clk), .rd_data(rd_data), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .unlocked(unlocked));

    srcr_regs #(.BLANK_CYCLES(20), .BLANK_CNT_W(17)) srcr_regs_inst (.sys_clk(sys_clk),
        .reset(reset), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .unlocked(unlocked),
        .third_pin_level(tpl), .switch_enable(sw_en), .third_general_pin_in(pin_in),
        .power_fail_comparator_out(pfo), .third_general_pin_out(pin_out),
        .third_general_pin_oe(pin_oe), .buck_warm_reset(warm_rst),
        .warm_reset_pin_select(warm_sel), .lockout_hysteresis_select(hyst),
        .switch_three_limit_select(lim3), .switch_two_limit_select(lim2),
        .switch_on(sw_on), .discharge_on(dis_on), .light_load_pulse_skip(llp),
        .buck_one_voltage(volt), .monitor_blank(blank));

    // ==========================================
    // Clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    // Compare and count
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    begin
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
    begin
        srcr_host_inst.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    end
    endtask

    task automatic cyc(input int k);
    begin
        repeat (k) @(posedge sys_clk);
        #5;
    end
    endtask

    task automatic report_and_stop;
    begin
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        tpl = 1'b0;
        sw_en = 3'h0;
        pin_in = 1'b1;
        pfo = 1'b1;
        cyc(3);
        reset = 1'b0;
        rdchk(8'h14, 8'h40);
        rdchk(8'h15, 8'h00);
        rdchk(8'h16, 8'h80);
        rdchk(8'h17, 8'h00);
        srcr_host_inst.wr(8'h16, 8'h3f);
        rdchk(8'h16, 8'h80);
        srcr_host_inst.set_unlock(1'b1);
        // Write to buck one, then time the blanking window
        srcr_host_inst.wr(8'h16, 8'h7f);
        for (n = 0; n < 6 && blank !== 1'b1; n++)
            cyc(1);
        n = 0;
        while (blank === 1'b1 && n < 100)
        begin
            n++;
            cyc(1);
        end
        chk("blank_len", 8'd20, 8'(n));
        rdchk(8'h16, 8'h3f);
        chk("light_load", 8'h00, {7'h00, llp});
        chk("voltage", 8'h3f, {2'h0, volt});
        // Go command lives outside the slice; voltage must stay put
        srcr_host_inst.wr(8'h1a, 8'h01);
        chk("voltage", 8'h3f, {2'h0, volt});
        chk("blank", 8'h00, {7'h00, blank});
        srcr_host_inst.wr(8'h16, 8'h80);
        chk("light_load", 8'h01, {7'h00, llp});
        // Every limit code, reserved bits set on write
        for (int i = 0; i < 4; i++)
        begin
            srcr_host_inst.wr(8'h14, {4'h3, 2'(i), ~2'(i)});
            chk("lim3", 8'(i), {6'h00, lim3});
            chk("lim2", 8'(3 - i), {6'h00, lim2});
            rdchk(8'h14, {4'h0, 2'(i), ~2'(i)});
        end
        chk("hyst", 8'h00, {7'h00, hyst});
        // Third pin as output, then as warm-reset input
        cyc(1);
        chk("pin_oe", 8'h01, {7'h00, pin_oe});
        tpl = 1'b1;
        cyc(2);
        chk("pin_oe", 8'h00, {7'h00, pin_oe});
        srcr_host_inst.wr(8'h14, 8'hc0);
        tpl = 1'b0;
        cyc(2);
        chk("pin_oe", 8'h00, {7'h00, pin_oe});
        chk("warm_sel", 8'h01, {7'h00, warm_sel});
        chk("hyst", 8'h01, {7'h00, hyst});
        pin_in = 1'b0;
        cyc(4);
        chk("warm_rst", 8'h01, {7'h00, warm_rst});
        pin_in = 1'b1;
        cyc(4);
        chk("warm_rst", 8'h00, {6'h00, pin_out, warm_rst});
        // Power-fail gating and discharge
        sw_en = 3'h7;
        srcr_host_inst.wr(8'h15, 8'hff);
        rdchk(8'h15, 8'h3f);
        chk("sw_on", 8'h07, {5'h00, sw_on});
        pfo = 1'b0;
        cyc(4);
        chk("sw_on", 8'h00, {5'h00, sw_on});
        chk("dis_on", 8'h07, {5'h00, dis_on});
        srcr_host_inst.wr(8'h15, 8'h13);
        cyc(1);
        chk("sw_on", 8'h05, {5'h00, sw_on});
        chk("dis_on", 8'h02, {5'h00, dis_on});
        pfo = 1'b1;
        cyc(4);
        chk("sw_on", 8'h07, {5'h00, sw_on});
        chk("dis_on", 8'h00, {5'h00, dis_on});
        // Reset in mid-run restores the reset values
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
        rdchk(8'h14, 8'h40);
        rdchk(8'h15, 8'h00);
        rdchk(8'h16, 8'h80);
        chk("sw_on", 8'h07, {5'h00, sw_on});
        report_and_stop();
    end
endmodule

`default_nettype wire
